// File: hw/lsc_pkg.sv
// constants and types shared by the light sensor control block
package lsc_pkg;
	// bus address and register map
	localparam logic [6:0] LSC_SLAVE_ADDR   = 7'h44;
	localparam logic [2:0] LSC_REG_OPCTL    = 3'h0;
	localparam logic [2:0] LSC_REG_SETUP    = 3'h1;
	localparam logic [2:0] LSC_REG_RES_LO   = 3'h2;
	localparam logic [2:0] LSC_REG_RES_HI   = 3'h3;
	localparam logic [2:0] LSC_REG_LOWER_LO = 3'h4;
	localparam logic [2:0] LSC_REG_LOWER_HI = 3'h5;
	localparam logic [2:0] LSC_REG_UPPER_LO = 3'h6;
	localparam logic [2:0] LSC_REG_UPPER_HI = 3'h7;
	// field positions of operation_control and conversion_setup
	localparam int LSC_MODE_LSB    = 5;
	localparam int LSC_FLAG_POS    = 2;
	localparam int LSC_PERSIST_LSB = 0;
	localparam int LSC_RES_LSB     = 2;
	localparam int LSC_RANGE_LSB   = 0;
	// reset values
	localparam logic [2:0]  LSC_MODE_RST    = 3'h0;
	localparam logic [1:0]  LSC_PERSIST_RST = 2'h0;
	localparam logic [3:0]  LSC_SETUP_RST   = 4'h0;
	localparam logic [15:0] LSC_RESULT_RST  = 16'h0000;
	localparam logic [15:0] LSC_LOWER_RST   = 16'h0000;
	localparam logic [15:0] LSC_UPPER_RST   = 16'hffff;
	// operating modes
	localparam logic [2:0]  LSC_MODE_OFF = 3'h0;
	localparam logic [2:0]  LSC_MODE_VIS = 3'h5;
	localparam logic [2:0]  LSC_MODE_IR  = 3'h6;
	// persistence counts m, selected by persist field
	localparam logic [4:0]  LSC_PERSIST_M0 = 5'h01;
	localparam logic [4:0]  LSC_PERSIST_M1 = 5'h04;
	localparam logic [4:0]  LSC_PERSIST_M2 = 5'h08;
	localparam logic [4:0]  LSC_PERSIST_M3 = 5'h10;
	// oscillator cycles per integration and result masks per resolution code
	localparam int          LSC_CYC_RES16 = 65536;
	localparam logic [15:0] LSC_TERM_RES12 = 16'h0fff;
	localparam logic [15:0] LSC_TERM_RES8  = 16'h00ff;
	localparam logic [15:0] LSC_TERM_RES4  = 16'h000f;
	localparam logic [15:0] LSC_MASK_RES16 = 16'hffff;
	// serial slave states, gray coded along the usual path
	typedef enum logic [2:0] {
		LSC_ST_IDLE = 3'b000,
		LSC_ST_ADDR = 3'b001,
		LSC_ST_AACK = 3'b011,
		LSC_ST_RX   = 3'b010,
		LSC_ST_RACK = 3'b110,
		LSC_ST_TX   = 3'b111,
		LSC_ST_TACK = 3'b101
	} lsc_state_e;
	// pin groups
	typedef struct packed {
		logic scl;
		logic sda;
	} lsc_bus_in_s;
	typedef struct packed {
		logic sda_out;
		logic sda_oe;
		logic alert_n_out;
		logic alert_n_oe;
	} lsc_bus_out_s;
	// configuration passed to the oscillator domain
	typedef struct packed {
		logic       run;
		logic [1:0] res;
	} lsc_cfg_s;
endpackage

// File: hw/lsc_top.sv
// serial slave, register bank, conversion timing and threshold alert of the light sensor
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - answer as slave only at seven-bit address 1000100; eighth bit selects read or write
// - receiver pulls data low in each acknowledge slot; master always drives clock
// - mode 000 powers down, 101 runs visible, 110 runs infrared, rest reserved
// - both command registers keep their contents until rewritten, except flag bit 2 of register zero
// - both result registers are read only; writes to them are ignored
// - result registers take each result whose conversion ends after the previous result has crossed over
// - result low byte at 02, high byte at 03; valid width follows resolution
// - out-of-window result sets flag bit 2 and pulls the alert pin low
// - flag and alert clear at the end of a transfer of register zero
// - flag raised only after m consecutive out-of-window results, m 1/4/8/16
// - resolution code selects 65536/4096/256/16 cycles and 16/12/8/4 bits
// - integration lasts two to the n oscillator cycles for resolution n
// - range field selects one of four full-scale spans for visible sensing
// - lower limit at 04/05, resets to zero
// - upper limit at 06/07, resets to all ones
// - after reset the device is powered down with zero results
// - conversion continues after the alert, so results may be overwritten
module lsc_top #(
	parameter int LONG_INT_CYCLES = lsc_pkg::LSC_CYC_RES16
) (
	// system clock and reset
	input  wire logic                  clk,
	input  wire logic                  sys_rst,
	// conversion oscillator domain and front-end sample
	input  wire logic                  osc_clk,
	input  wire logic [15:0]           adc_sample,
	// serial bus and alert pins
	input  wire lsc_pkg::lsc_bus_in_s  bus_in,
	output var  lsc_pkg::lsc_bus_out_s bus_out,
	// front-end controls
	output logic                       conv_run,
	output logic                       sense_ir,
	output logic [1:0]                 full_scale_span
);
	import lsc_pkg::*;

	// elaboration check: the counter serves powers of two from 32 to 65536 only
	if (LONG_INT_CYCLES < 32 || LONG_INT_CYCLES > LSC_CYC_RES16 ||
	    (LONG_INT_CYCLES & (LONG_INT_CYCLES - 1)) != 0) begin : g_bad_cycles
		$error("LONG_INT_CYCLES must be a power of two from 32 to 65536");
	end

	localparam logic [15:0] TERM_RES16 = 16'(LONG_INT_CYCLES - 1);

	// state of the system clock domain
	typedef struct packed {
		logic [2:0]  scl_sync;
		logic [2:0]  sda_sync;
		logic        scl_f;
		logic        sda_f;
		lsc_state_e  state;
		logic [3:0]  bit_cnt;
		logic [7:0]  shift;
		logic        rw;
		logic        first;
		logic        nack;
		logic [2:0]  ptr;
		logic        sda_oe;
		logic [2:0]  mode_sel;
		logic [1:0]  persist_sel;
		logic [3:0]  setup;
		logic [15:0] result;
		logic [15:0] lower_limit;
		logic [15:0] upper_limit;
		logic        flag;
		logic [4:0]  out_cnt;
		lsc_cfg_s    cfg;
		logic [2:0]  req_sync;
		logic        req_f;
		logic        ack_tgl;
	} lsc_sys_s;

	// state of the oscillator domain
	typedef struct packed {
		logic [1:0]  rst_sync;
		lsc_cfg_s    cfg_s0;
		lsc_cfg_s    cfg_s1;
		lsc_cfg_s    cfg_s2;
		lsc_cfg_s    cfg_f;
		logic [15:0] cnt;
		logic [15:0] hold;
		logic        req_tgl;
		logic [2:0]  ack_sync;
		logic        ack_f;
	} lsc_osc_s;

	lsc_sys_s s_r;
	lsc_sys_s s_nxt;
	lsc_osc_s o_r;
	lsc_osc_s o_nxt;

	// register read mux
	function automatic logic [7:0] read_reg(input lsc_sys_s s);
		logic [7:0] v;
		v = 8'h00;
		unique case (s.ptr)
			LSC_REG_OPCTL:    v = {s.mode_sel, 2'b00, s.flag, s.persist_sel};
			LSC_REG_SETUP:    v = {4'h0, s.setup};
			LSC_REG_RES_LO:   v = s.result[7:0];
			LSC_REG_RES_HI:   v = s.result[15:8];
			LSC_REG_LOWER_LO: v = s.lower_limit[7:0];
			LSC_REG_LOWER_HI: v = s.lower_limit[15:8];
			LSC_REG_UPPER_LO: v = s.upper_limit[7:0];
			LSC_REG_UPPER_HI: v = s.upper_limit[15:8];
		endcase
		return v;
	endfunction

	// persistence count m for the selected code
	function automatic logic [4:0] persist_m(input logic [1:0] sel);
		logic [4:0] m;
		m = LSC_PERSIST_M0;
		unique case (sel)
			2'h0: m = LSC_PERSIST_M0;
			2'h1: m = LSC_PERSIST_M1;
			2'h2: m = LSC_PERSIST_M2;
			2'h3: m = LSC_PERSIST_M3;
		endcase
		return m;
	endfunction

	// system domain next state: bus slave, registers, threshold logic
	always_comb begin
		logic       scl_now;
		logic       sda_now;
		logic       rise;
		logic       fall;
		logic       start;
		logic       stop;
		logic       req_now;
		logic       set_flag;
		logic       clr_flag;
		logic       outside;
		logic [7:0] rd;
		scl_now  = 1'b0;
		sda_now  = 1'b0;
		rise     = 1'b0;
		fall     = 1'b0;
		start    = 1'b0;
		stop     = 1'b0;
		req_now  = 1'b0;
		set_flag = 1'b0;
		clr_flag = 1'b0;
		outside  = 1'b0;
		rd       = read_reg(s_r);
		s_nxt    = s_r;

		// pin synchronisers: a change counts once stages two and three agree
		s_nxt.scl_sync = {s_r.scl_sync[1:0], bus_in.scl};
		s_nxt.sda_sync = {s_r.sda_sync[1:0], bus_in.sda};
		scl_now = (s_r.scl_sync[1] == s_r.scl_sync[2]) ? s_r.scl_sync[2] : s_r.scl_f;
		sda_now = (s_r.sda_sync[1] == s_r.sda_sync[2]) ? s_r.sda_sync[2] : s_r.sda_f;
		s_nxt.scl_f = scl_now;
		s_nxt.sda_f = sda_now;
		rise  = scl_now & ~s_r.scl_f;
		fall  = ~scl_now & s_r.scl_f;
		start = s_r.scl_f & scl_now & s_r.sda_f & ~sda_now;
		stop  = s_r.scl_f & scl_now & ~s_r.sda_f & sda_now;

		// configuration handed to the oscillator domain
		s_nxt.cfg.run = (s_r.mode_sel == LSC_MODE_VIS) || (s_r.mode_sel == LSC_MODE_IR);
		s_nxt.cfg.res = s_r.setup[LSC_RES_LSB +: 2];

		// new result from the oscillator domain, toggle handshake
		s_nxt.req_sync = {s_r.req_sync[1:0], o_r.req_tgl};
		req_now = (s_r.req_sync[1] == s_r.req_sync[2]) ? s_r.req_sync[2] : s_r.req_f;
		s_nxt.req_f = req_now;
		if (req_now != s_r.ack_tgl) begin
			s_nxt.ack_tgl = req_now;
			s_nxt.result  = o_r.hold;
			outside = (o_r.hold < s_r.lower_limit) || (o_r.hold > s_r.upper_limit);
			if (outside) begin
				if (s_r.out_cnt != LSC_PERSIST_M3) begin
					s_nxt.out_cnt = s_r.out_cnt + 5'h01;
				end
				if (s_r.out_cnt + 5'h01 >= persist_m(s_r.persist_sel)) begin
					set_flag = 1'b1;
				end
			end else begin
				s_nxt.out_cnt = 5'h00;
			end
		end

		// serial slave
		if (start) begin
			s_nxt.state   = LSC_ST_ADDR;
			s_nxt.bit_cnt = 4'h0;
			s_nxt.sda_oe  = 1'b0;
		end else if (stop) begin
			s_nxt.state  = LSC_ST_IDLE;
			s_nxt.sda_oe = 1'b0;
		end else begin
			unique case (s_r.state)
				LSC_ST_IDLE: begin
					s_nxt.sda_oe = 1'b0;
				end
				LSC_ST_ADDR: begin
					if (rise) begin
						s_nxt.shift   = {s_r.shift[6:0], sda_now};
						s_nxt.bit_cnt = s_r.bit_cnt + 4'h1;
					end else if (fall && s_r.bit_cnt == 4'h8) begin
						s_nxt.bit_cnt = 4'h0;
						if (s_r.shift[7:1] == LSC_SLAVE_ADDR) begin
							s_nxt.state  = LSC_ST_AACK;
							s_nxt.sda_oe = 1'b1;
							s_nxt.rw     = s_r.shift[0];
							s_nxt.first  = 1'b1;
						end else begin
							s_nxt.state = LSC_ST_IDLE;
						end
					end
				end
				LSC_ST_AACK: begin
					if (fall) begin
						if (s_r.rw) begin
							s_nxt.state  = LSC_ST_TX;
							s_nxt.shift  = rd;
							s_nxt.sda_oe = ~rd[7];
						end else begin
							s_nxt.state  = LSC_ST_RX;
							s_nxt.sda_oe = 1'b0;
						end
					end
				end
				LSC_ST_RX: begin
					if (rise) begin
						s_nxt.shift   = {s_r.shift[6:0], sda_now};
						s_nxt.bit_cnt = s_r.bit_cnt + 4'h1;
					end else if (fall && s_r.bit_cnt == 4'h8) begin
						s_nxt.bit_cnt = 4'h0;
						s_nxt.state   = LSC_ST_RACK;
						s_nxt.sda_oe  = 1'b1;
						if (s_r.first) begin
							s_nxt.first = 1'b0;
							s_nxt.ptr   = s_r.shift[2:0];
						end else begin
							// writes to the result registers fall through unhandled
							unique case (s_r.ptr)
								LSC_REG_OPCTL: begin
									s_nxt.mode_sel    = s_r.shift[LSC_MODE_LSB +: 3];
									s_nxt.persist_sel = s_r.shift[LSC_PERSIST_LSB +: 2];
									clr_flag          = 1'b1;
								end
								LSC_REG_SETUP:    s_nxt.setup = s_r.shift[3:0];
								LSC_REG_LOWER_LO: s_nxt.lower_limit[7:0]  = s_r.shift;
								LSC_REG_LOWER_HI: s_nxt.lower_limit[15:8] = s_r.shift;
								LSC_REG_UPPER_LO: s_nxt.upper_limit[7:0]  = s_r.shift;
								LSC_REG_UPPER_HI: s_nxt.upper_limit[15:8] = s_r.shift;
								default: ;
							endcase
						end
					end
				end
				LSC_ST_RACK: begin
					if (fall) begin
						s_nxt.state  = LSC_ST_RX;
						s_nxt.sda_oe = 1'b0;
					end
				end
				LSC_ST_TX: begin
					if (fall) begin
						if (s_r.bit_cnt == 4'h7) begin
							s_nxt.bit_cnt = 4'h0;
							s_nxt.state   = LSC_ST_TACK;
							s_nxt.sda_oe  = 1'b0; // master acknowledges a read byte
							clr_flag      = (s_r.ptr == LSC_REG_OPCTL);
						end else begin
							s_nxt.bit_cnt = s_r.bit_cnt + 4'h1;
							s_nxt.shift   = {s_r.shift[6:0], 1'b0};
							s_nxt.sda_oe  = ~s_r.shift[6]; // open drain: drive only zeros
						end
					end
				end
				LSC_ST_TACK: begin
					if (rise) begin
						s_nxt.nack = sda_now;
					end else if (fall) begin
						if (s_r.nack) begin
							s_nxt.state = LSC_ST_IDLE;
						end else begin
							s_nxt.state  = LSC_ST_TX;
							s_nxt.shift  = rd;
							s_nxt.sda_oe = ~rd[7];
						end
					end
				end
				default: begin
					s_nxt.state  = LSC_ST_IDLE;
					s_nxt.sda_oe = 1'b0;
				end
			endcase
		end

		// sticky flag: a new event wins over a clear in the same cycle
		s_nxt.flag = (s_r.flag & ~clr_flag) | set_flag;
	end

	// system domain registers
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			s_r             <= '0;
			s_r.scl_sync    <= 3'h7;
			s_r.sda_sync    <= 3'h7;
			s_r.scl_f       <= 1'b1;
			s_r.sda_f       <= 1'b1;
			s_r.state       <= LSC_ST_IDLE;
			s_r.mode_sel    <= LSC_MODE_RST;
			s_r.persist_sel <= LSC_PERSIST_RST;
			s_r.setup       <= LSC_SETUP_RST;
			s_r.result      <= LSC_RESULT_RST;
			s_r.lower_limit <= LSC_LOWER_RST;
			s_r.upper_limit <= LSC_UPPER_RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	// oscillator domain next state: integration counter and result capture
	always_comb begin
		logic [15:0] term;
		logic [15:0] mask;
		term  = TERM_RES16;
		mask  = LSC_MASK_RES16;
		o_nxt = o_r;
		o_nxt.rst_sync = {o_r.rst_sync[0], 1'b1};
		o_nxt.cfg_s0   = s_r.cfg;
		o_nxt.cfg_s1   = o_r.cfg_s0;
		o_nxt.cfg_s2   = o_r.cfg_s1;
		if (o_r.cfg_s1 == o_r.cfg_s2) begin
			o_nxt.cfg_f = o_r.cfg_s2;
		end
		o_nxt.ack_sync = {o_r.ack_sync[1:0], s_r.ack_tgl};
		if (o_r.ack_sync[1] == o_r.ack_sync[2]) begin
			o_nxt.ack_f = o_r.ack_sync[2];
		end
		// cycles per integration and valid result width
		unique case (o_r.cfg_f.res)
			2'h0: begin term = TERM_RES16;     mask = LSC_MASK_RES16; end
			2'h1: begin term = LSC_TERM_RES12; mask = LSC_TERM_RES12; end
			2'h2: begin term = LSC_TERM_RES8;  mask = LSC_TERM_RES8;  end
			2'h3: begin term = LSC_TERM_RES4;  mask = LSC_TERM_RES4;  end
		endcase
		if (!o_r.rst_sync[1] || !o_r.cfg_f.run) begin
			o_nxt.cnt = 16'h0000; // powered down: no integration
		end else if (o_r.cnt >= term) begin
			o_nxt.cnt = 16'h0000;
			// a result finished while the last one is still crossing is dropped
			if (o_r.ack_f == o_r.req_tgl) begin
				o_nxt.hold    = adc_sample & mask;
				o_nxt.req_tgl = ~o_r.req_tgl;
			end
		end else begin
			o_nxt.cnt = o_r.cnt + 16'h0001;
		end
	end

	// oscillator domain registers
	always_ff @(posedge osc_clk or posedge sys_rst) begin
		if (sys_rst) begin
			o_r <= '0;
		end else begin
			o_r <= o_nxt;
		end
	end

	// pins and front-end controls
	always_comb begin
		bus_out.sda_out     = 1'b0;
		bus_out.sda_oe      = s_r.sda_oe;
		bus_out.alert_n_out = 1'b0;
		bus_out.alert_n_oe  = s_r.flag;
	end
	assign conv_run        = o_r.cfg_f.run;
	assign sense_ir        = (s_r.mode_sel == LSC_MODE_IR);
	assign full_scale_span = s_r.setup[LSC_RANGE_LSB +: 2];
endmodule
`default_nettype wire

// File: testbench/lsc_monitor.sv
// port checker of the light sensor control block
`timescale 1ns/1ps
`default_nettype none
module lsc_monitor #(
	parameter int LONG_INT_CYCLES = lsc_pkg::LSC_CYC_RES16
) (
	// clocks and reset
	input wire logic                  clk,
	input wire logic                  sys_rst,
	input wire logic                  osc_clk,
	// observed ports
	input wire logic [15:0]           adc_sample,
	input wire lsc_pkg::lsc_bus_in_s  bus_in,
	input wire lsc_pkg::lsc_bus_out_s bus_out,
	input wire logic                  conv_run,
	input wire logic                  sense_ir,
	input wire logic [1:0]            full_scale_span
);
	import lsc_pkg::*;
	// everything is sampled on the system clock, idle in reset
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);
	// open-drain pins only ever pull low
	sda_drain_a: assert property (!bus_out.sda_out) else $error("data pin driven high");
	alert_drain_a: assert property (!bus_out.alert_n_out) else $error("alert pin driven high");
	// the slave moves data only while the clock is low, else it fakes a start or stop
	sda_change_a: assert property ($changed(bus_out.sda_oe) |-> !bus_in.scl)
		else $error("data moved with clock high");
	flag_clear_a: assert property ($fell(bus_out.alert_n_oe) |-> !bus_in.scl)
		else $error("alert cleared outside a byte end");
	// command fields change only together with an acknowledged byte
	span_ack_a: assert property ($changed(full_scale_span) |-> ##[0:3] bus_out.sda_oe)
		else $error("range changed without a write");
	mode_ack_a: assert property ($changed(sense_ir) |-> ##[0:3] bus_out.sda_oe)
		else $error("mode changed without a write");
	// infrared mode starts the integrator promptly
	ir_run_a: assert property ($rose(sense_ir) |-> ##[0:3] conv_run)
		else $error("infrared mode not converting");
	// leaving reset the block is powered down and quiet
	reset_idle_a: assert property ($fell(sys_rst) |-> !conv_run && !sense_ir && !bus_out.alert_n_oe)
		else $error("not idle after reset");
endmodule
bind lsc_top lsc_monitor #(.LONG_INT_CYCLES(LONG_INT_CYCLES)) u_mon (
	.clk(clk),
	.sys_rst(sys_rst),
	.osc_clk(osc_clk),
	.adc_sample(adc_sample),
	.bus_in(bus_in),
	.bus_out(bus_out),
	.conv_run(conv_run),
	.sense_ir(sense_ir),
	.full_scale_span(full_scale_span)
);
`default_nettype wire

// File: testbench/lsc_host.sv
// two-wire bus master standing in for the host controller
`timescale 1ns/1ps
`default_nettype none
module lsc_host (
	// system clock and resolved data line
	input  wire logic clk,
	input  wire logic sda_pin,
	// lines driven by the master
	output var logic  scl,
	output var logic  sda_low
);
	import lsc_pkg::*;
	// bus idles released
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	// wait n clocks, landing just after an edge
	task automatic dly(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// start or repeated start, the master alone drives the clock
	task automatic start();
		dly(2);
		sda_low = 1'b0;
		dly(6);
		scl = 1'b1;
		dly(6);
		sda_low = 1'b1;
		dly(6);
		scl = 1'b0;
	endtask
	// stop: data rises with the clock high
	task automatic stop();
		dly(2);
		sda_low = 1'b1;
		dly(6);
		scl = 1'b1;
		dly(6);
		sda_low = 1'b0;
		dly(6);
	endtask
	// one bit: data set in the low phase, sampled at the end of the high phase
	task automatic bit_x(input logic b, output logic s);
		dly(2);
		sda_low = !b;
		dly(6);
		scl = 1'b1;
		dly(6);
		s = sda_pin;
		scl = 1'b0;
	endtask
	// eight bits, then the line is released for the receiver
	task automatic xfer(input logic [7:0] d, output logic [7:0] q, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_x(d[i], s);
			q[i] = s;
		end
		bit_x(1'b1, s); // receiver pulls acknowledge low
		ack = !s;
	endtask
	// register write: pointer byte, then data byte
	task automatic wr(input logic [6:0] a, input logic [7:0] p, input logic [7:0] d, output logic ok);
		logic [7:0] q;
		logic k1;
		logic k2;
		logic k3;
		start();
		xfer({a, 1'b0}, q, k1);
		xfer(p, q, k2);
		xfer(d, q, k3);
		stop();
		ok = k1 & k2 & k3;
	endtask
	// register read through a repeated start, single byte then not acknowledged
	task automatic rd(input logic [7:0] p, output logic [7:0] d);
		logic [7:0] q;
		logic k;
		start();
		xfer({LSC_SLAVE_ADDR, 1'b0}, q, k);
		xfer(p, q, k);
		start();
		xfer({LSC_SLAVE_ADDR, 1'b1}, q, k);
		xfer(8'hff, d, k);
		stop();
	endtask
endmodule
`default_nettype wire

// File: testbench/tb_top.sv
// self-checking bench of the light sensor control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin fail_count++; $display("unexpected %s %h %h", n, e, g); end end
module tb_top;
	import lsc_pkg::*;
	localparam int LONG = 32;
	logic         clk;
	logic         osc_clk;
	logic         sys_rst;
	logic [15:0]  adc_sample;
	logic         scl;
	logic         sda_low;
	logic         sda_line;
	lsc_bus_in_s  bus_in;
	lsc_bus_out_s bus_out;
	logic         conv_run;
	logic         sense_ir;
	logic [1:0]   full_scale_span;
	logic [7:0]   mdl [8];
	logic [7:0]   rv;
	logic [15:0]  lfsr;
	logic [15:0]  res;
	logic         ok;
	int           fail_count;
	int           checks;
	// pulled-up data line, low when either side pulls
	assign sda_line = !(sda_low | bus_out.sda_oe);
	assign bus_in = {scl, sda_line};
	// next pseudo-random value
	function automatic logic [15:0] nxt(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction
	// reset pulse and register model back to defaults
	task automatic do_reset();
		sys_rst = 1'b1;
		host.dly(5);
		sys_rst = 1'b0;
		host.dly(6);
		mdl = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'hff};
	endtask
	// write one register, pointer high bits are junk on purpose
	task automatic wreg(input logic [2:0] a, input logic [7:0] d);
		host.wr(LSC_SLAVE_ADDR, {5'h15, a}, d, ok);
		`CHK("ack", 1'b1, ok)
		case (a)
			3'h0: mdl[0] = {d[7:5], 5'h0} | {6'h0, d[1:0]};
			3'h1: mdl[1] = {4'h0, d[3:0]};
			3'h2, 3'h3: ;
			default: mdl[a] = d;
		endcase
	endtask
	// read one register and compare with the model
	task automatic chk_reg(input logic [2:0] a);
		host.rd({5'h0, a}, rv);
		`CHK("register", mdl[a], rv)
	endtask
	// verdict
	task automatic test_done();
		$display("checks %0d mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	// partner and device
	lsc_host host (.clk(clk), .sda_pin(sda_line), .scl(scl), .sda_low(sda_low));
	lsc_top #(.LONG_INT_CYCLES(LONG)) DUT (
		.clk(clk),
		.sys_rst(sys_rst),
		.osc_clk(osc_clk),
		.adc_sample(adc_sample),
		.bus_in(bus_in),
		.bus_out(bus_out),
		.conv_run(conv_run),
		.sense_ir(sense_ir),
		.full_scale_span(full_scale_span)
	);
	// system clock and free-running oscillator
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	initial begin
		osc_clk = 1'b0;
		#3;
		forever #6 osc_clk = ~osc_clk;
	end
	// cut a hang short, run needs about 36000 clocks
	initial begin
		#8000000;
		fail_count++;
		test_done();
	end
	// main sequence
	initial begin
		sys_rst = 1'b1;
		adc_sample = 16'h0000;
		lfsr = 16'h6ddf;
		fail_count = 0;
		checks = 0;
		do_reset();
		for (int a = 0; a < 8; a++) chk_reg(3'(a));
		wreg(3'h0, 8'h00);
		// random contents in every writable register, mode kept off, then read back
		for (int a = 0; a < 8; a++) begin
			lfsr = nxt(lfsr);
			wreg(3'(a), (a == 0) ? (lfsr[7:0] & 8'h1f) : lfsr[7:0]);
		end
		for (int a = 0; a < 8; a++) chk_reg(3'(a));
		host.wr(7'h45, 8'h01, 8'h0f, ok);
		`CHK("foreign ack", 1'b0, ok)
		chk_reg(3'h1);
		do_reset();
		// every mode code, reserved ones stay powered down
		for (int m = 0; m < 8; m++) begin
			wreg(3'h0, 8'(m << 5));
			host.dly(4);
			`CHK("ir", (m == 6), sense_ir)
			`CHK("run", (m == 5 || m == 6), conv_run)
		end
		// every resolution with a random sample, masked to its width
		wreg(3'h0, 8'ha0);
		for (int r = 0; r < 4; r++) begin
			wreg(3'h1, {4'h0, r[1:0], ~r[1:0]});
			`CHK("span", ~r[1:0], full_scale_span)
			lfsr = nxt(lfsr);
			adc_sample = lfsr;
			host.dly(1100);
			res = adc_sample & (16'hffff >> (4 * r));
			mdl[2] = res[7:0];
			mdl[3] = res[15:8];
			chk_reg(3'h2);
			chk_reg(3'h3);
		end
		// persistence of four with a below-limit sample, 12-bit integrations
		do_reset();
		wreg(3'h1, 8'h04);
		wreg(3'h5, 8'h01);
		lfsr = nxt(lfsr);
		adc_sample = {8'h00, lfsr[7:0]}; // strictly below the lower limit
		wreg(3'h0, 8'ha1);
		host.dly(1720);
		`CHK("alert early", 1'b0, bus_out.alert_n_oe)
		host.dly(490);
		`CHK("alert", 1'b1, bus_out.alert_n_oe)
		lfsr = nxt(lfsr);
		adc_sample = {8'h01, lfsr[7:0]}; // back inside the window
		host.dly(1000);
		`CHK("alert sticky", 1'b1, bus_out.alert_n_oe)
		mdl[2] = adc_sample[7:0];
		mdl[3] = adc_sample[15:8];
		chk_reg(3'h2);
		chk_reg(3'h3);
		mdl[0] = 8'ha5;
		chk_reg(3'h0);
		mdl[0] = 8'ha1;
		`CHK("alert cleared", 1'b0, bus_out.alert_n_oe)
		host.dly(1000);
		`CHK("alert quiet", 1'b0, bus_out.alert_n_oe)
		chk_reg(3'h0);
		wreg(3'h0, 8'h00);
		host.dly(4);
		`CHK("powered down", 1'b0, conv_run)
		test_done();
	end
endmodule
`default_nettype wire
